// [hdl/adc_channel_one_config_regs.v]
// register bank for channel one input setup, gain, volume and gain trim
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "ch1_cfg_defines.vh"
module adc_channel_one_config_regs (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    output reg        first_channel_input_kind,
    output reg        first_channel_mic_input,
    output reg        path_analog_diff,
    output reg        path_analog_single,
    output reg        path_pdm_mic,
    output reg        path_dc_coupled,
    output reg  [2:0] impedance_select_onehot,
    output reg        dynamic_range_enhancer_on,
    output reg        automatic_gain_controller_on,
    output reg  [5:0] channel_gain_db,
    output reg        channel_muted,
    output reg  [8:0] volume_half_db,
    output reg  [4:0] trim_tenth_db,
    output reg        reserved_code_seen
);
    // stored registers
    reg  [7:0] input_setup_ff;
    reg  [7:0] analog_gain_ff;
    reg  [7:0] digital_volume_ff;
    reg  [7:0] gain_trim_ff;
    reg  [7:0] range_gain_mode_ff;
    reg  [7:0] nxt_rdata;

    // decoded fields
    wire [1:0] first_channel_source_select;
    wire       first_channel_coupling_select;
    wire [1:0] first_channel_impedance_select;
    wire       first_channel_range_gain_enable;
    wire [5:0] first_channel_analog_gain_code;
    wire [7:0] first_channel_volume_code;
    wire [3:0] first_channel_gain_trim_code;
    wire       dec_analog;
    wire       dec_single;
    wire       dec_pdm;
    wire       dec_dc;
    wire [2:0] dec_imp;
    wire [5:0] dec_gain;
    wire       dec_reserved;
    wire       dec_mute;
    wire [8:0] dec_half_db;

    // writes merge only writable bits, so reserved bits stay zero
    function [7:0] masked;
        input [7:0] data;
        input [7:0] mask;
        begin
            masked = data & mask;
        end
    endfunction

    // register writes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            input_setup_ff     <= `INPUT_SETUP_RST;
            analog_gain_ff     <= `ANALOG_GAIN_RST;
            digital_volume_ff  <= `DIGITAL_VOLUME_RST;
            gain_trim_ff       <= `GAIN_TRIM_RST;
            range_gain_mode_ff <= `RANGE_GAIN_MODE_RST;
        end else if (reg_write) begin
            case (reg_addr)
                `INPUT_SETUP_ADDR: begin
                    input_setup_ff <= masked(reg_wdata, `INPUT_SETUP_MASK);
                end
                `ANALOG_GAIN_ADDR: begin
                    analog_gain_ff <= masked(reg_wdata, `ANALOG_GAIN_MASK);
                end
                `DIGITAL_VOLUME_ADDR: begin
                    digital_volume_ff <= masked(reg_wdata, `DIGITAL_VOLUME_MASK);
                end
                `GAIN_TRIM_ADDR: begin
                    gain_trim_ff <= masked(reg_wdata, `GAIN_TRIM_MASK);
                end
                `RANGE_GAIN_MODE_ADDR: begin
                    range_gain_mode_ff <= masked(reg_wdata, `RANGE_GAIN_MODE_MASK);
                end
                default: begin
                    input_setup_ff <= input_setup_ff;
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `INPUT_SETUP_ADDR:     nxt_rdata = input_setup_ff;
            `ANALOG_GAIN_ADDR:     nxt_rdata = analog_gain_ff;
            `DIGITAL_VOLUME_ADDR:  nxt_rdata = digital_volume_ff;
            `GAIN_TRIM_ADDR:       nxt_rdata = gain_trim_ff;
            `RANGE_GAIN_MODE_ADDR: nxt_rdata = range_gain_mode_ff;
            default:               nxt_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // field extraction
    assign first_channel_source_select     = input_setup_ff[`SRC_HI:`SRC_LO];
    assign first_channel_coupling_select   = input_setup_ff[`COUPLING_BIT];
    assign first_channel_impedance_select  = input_setup_ff[`IMP_HI:`IMP_LO];
    assign first_channel_range_gain_enable = input_setup_ff[`RANGE_EN_BIT];
    assign first_channel_analog_gain_code  = analog_gain_ff[`GAIN_HI:`GAIN_LO];
    assign first_channel_volume_code       = digital_volume_ff;
    assign first_channel_gain_trim_code    = gain_trim_ff[`TRIM_HI:`TRIM_LO];

    // front-end decode
    analog_front_decode u_front (
        .source_code       (first_channel_source_select),
        .coupling_bit      (first_channel_coupling_select),
        .impedance_code    (first_channel_impedance_select),
        .gain_code         (first_channel_analog_gain_code),
        .path_analog       (dec_analog),
        .path_single_ended (dec_single),
        .path_pdm          (dec_pdm),
        .dc_coupled        (dec_dc),
        .impedance_onehot  (dec_imp),
        .gain_db           (dec_gain),
        .code_reserved     (dec_reserved)
    );

    // volume decode
    volume_level_decode u_volume (
        .volume_code    (first_channel_volume_code),
        .volume_mute    (dec_mute),
        .volume_half_db (dec_half_db)
    );

    // registered control outputs toward the signal path
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_channel_input_kind     <= 1'b0;
            first_channel_mic_input      <= 1'b1;
            path_analog_diff             <= 1'b1;
            path_analog_single           <= 1'b0;
            path_pdm_mic                 <= 1'b0;
            path_dc_coupled              <= 1'b0;
            impedance_select_onehot      <= 3'h1;
            dynamic_range_enhancer_on    <= 1'b0;
            automatic_gain_controller_on <= 1'b0;
            channel_gain_db              <= 6'h00;
            channel_muted                <= 1'b0;
            volume_half_db               <= 9'h000;
            trim_tenth_db                <= 5'h00;
            reserved_code_seen           <= 1'b0;
        end else begin
            first_channel_input_kind     <= input_setup_ff[`KIND_BIT];
            first_channel_mic_input      <= ~input_setup_ff[`KIND_BIT];
            path_analog_diff             <= dec_analog & ~dec_single;
            path_analog_single           <= dec_single;
            path_pdm_mic                 <= dec_pdm;
            path_dc_coupled              <= dec_dc;
            impedance_select_onehot      <= dec_imp;
            // enable picks one of the two by the mode bit
            dynamic_range_enhancer_on    <= first_channel_range_gain_enable &
                                            ~range_gain_mode_ff[`MODE_SELECT_BIT];
            automatic_gain_controller_on <= first_channel_range_gain_enable &
                                            range_gain_mode_ff[`MODE_SELECT_BIT];
            channel_gain_db              <= dec_gain;
            channel_muted                <= dec_mute;
            volume_half_db               <= dec_half_db;
            // trim in signed tenths of a dB, code 8 is zero
            trim_tenth_db                <= {1'b0, first_channel_gain_trim_code} -
                                            {1'b0, `TRIM_UNITY_CODE};
            reserved_code_seen           <= dec_reserved;
        end
    end
endmodule

// [hdl/ch1_cfg_defines.vh]
// register offsets, field positions, reset values and level constants for channel one setup
`ifndef CH1_CFG_DEFINES_VH
`define CH1_CFG_DEFINES_VH

// register offsets on page 0
`define INPUT_SETUP_ADDR     8'h3c
`define ANALOG_GAIN_ADDR     8'h3d
`define DIGITAL_VOLUME_ADDR  8'h3e
`define GAIN_TRIM_ADDR       8'h3f
`define RANGE_GAIN_MODE_ADDR 8'h6c

// reset values
`define INPUT_SETUP_RST      8'h00
`define ANALOG_GAIN_RST      8'h00
`define DIGITAL_VOLUME_RST   8'hc9
`define GAIN_TRIM_RST        8'h80
`define RANGE_GAIN_MODE_RST  8'h00

// writable bit masks
`define INPUT_SETUP_MASK     8'hfd
`define ANALOG_GAIN_MASK     8'hfc
`define DIGITAL_VOLUME_MASK  8'hff
`define GAIN_TRIM_MASK       8'hf0
`define RANGE_GAIN_MODE_MASK 8'h08

// field positions
`define KIND_BIT             7
`define SRC_HI               6
`define SRC_LO               5
`define COUPLING_BIT         4
`define IMP_HI               3
`define IMP_LO               2
`define RANGE_EN_BIT         0
`define GAIN_HI              7
`define GAIN_LO              2
`define TRIM_HI              7
`define TRIM_LO              4
`define MODE_SELECT_BIT      3

// source codes
`define SRC_ANALOG_DIFF      2'h0
`define SRC_ANALOG_SE        2'h1
`define SRC_PDM              2'h2

// code limits and level arithmetic
`define GAIN_CODE_MAX        6'h2a
`define IMP_CODE_MAX         2'h2
`define VOL_UNITY_CODE       8'hc9
`define TRIM_UNITY_CODE      4'h8
// volume code 1 is -100 dB: half-dB level = code - 201
`define TRIM_PER_TENTH       4'h1

`endif

// [hdl/volume_level_decode.v]
// decodes the digital volume code into mute and a signed half-dB level
`timescale 1ns/1ns
`include "ch1_cfg_defines.vh"
module volume_level_decode (
    input  wire [7:0] volume_code,
    output wire       volume_mute,
    output wire [8:0] volume_half_db
);
    // code zero mutes; others step 0.5 dB from -100 dB at code 1
    assign volume_mute    = (volume_code == 8'h00);
    assign volume_half_db = {1'b0, volume_code} - {1'b0, `VOL_UNITY_CODE};
endmodule

// [hdl/analog_front_decode.v]
// decodes source, coupling, impedance and gain fields into front-end controls
`timescale 1ns/1ns
`include "ch1_cfg_defines.vh"
module analog_front_decode (
    input  wire [1:0] source_code,
    input  wire       coupling_bit,
    input  wire [1:0] impedance_code,
    input  wire [5:0] gain_code,
    output wire       path_analog,
    output wire       path_single_ended,
    output wire       path_pdm,
    output wire       dc_coupled,
    output wire [2:0] impedance_onehot,
    output wire [5:0] gain_db,
    output wire       code_reserved
);
    // source decode; code 3 selects no path
    assign path_analog       = (source_code == `SRC_ANALOG_DIFF) ||
                               (source_code == `SRC_ANALOG_SE);
    assign path_single_ended = (source_code == `SRC_ANALOG_SE);
    assign path_pdm          = (source_code == `SRC_PDM);
    // coupling only matters on an analog path
    assign dc_coupled        = path_analog & coupling_bit;
    // impedance one-hot: 2.5k, 10k, 20k; reserved code selects none
    assign impedance_onehot  = path_analog ? {impedance_code == 2'h2,
                                              impedance_code == 2'h1,
                                              impedance_code == 2'h0} : 3'h0;
    // gain in whole dB, reserved codes clamp to the top step
    assign gain_db           = (gain_code > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX : gain_code;
    // flags any reserved code written by the host
    assign code_reserved     = (source_code == 2'h3) || (impedance_code == 2'h3) ||
                               (gain_code > `GAIN_CODE_MAX);
endmodule

// [verification/ch1_cfg_regs_asserts.sv]
// port assertions for the channel one configuration register bank
`timescale 1ns/1ns
module ch1_cfg_regs_asserts (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    input wire       first_channel_input_kind,
    input wire       first_channel_mic_input,
    input wire       path_analog_diff,
    input wire       path_analog_single,
    input wire       path_pdm_mic,
    input wire       path_dc_coupled,
    input wire [2:0] impedance_select_onehot,
    input wire       dynamic_range_enhancer_on,
    input wire       automatic_gain_controller_on,
    input wire [5:0] channel_gain_db,
    input wire       channel_muted,
    input wire [8:0] volume_half_db,
    input wire [4:0] trim_tenth_db
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // read data only in the cycle after a read
    a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_kind_mic_inverse: assert property (first_channel_mic_input != first_channel_input_kind)
        else $error("input kind and microphone flag disagree");
    a_path_single: assert property ($onehot0({path_analog_diff, path_analog_single, path_pdm_mic}))
        else $error("more than one input path selected");
    a_dc_analog_only: assert property (path_dc_coupled |-> !path_pdm_mic)
        else $error("dc coupling shown on digital source");
    a_imp_one_select: assert property ($onehot0(impedance_select_onehot))
        else $error("more than one impedance selected");
    a_range_gain_excl: assert property (!(dynamic_range_enhancer_on && automatic_gain_controller_on))
        else $error("enhancer and gain controller both on");
    // written codes reach the decoded outputs two cycles later
    a_gain_follows: assert property (reg_write && reg_addr == 8'h3d && reg_wdata[7:2] <= 6'h2a
        |-> ##2 channel_gain_db == $past(reg_wdata[7:2], 2))
        else $error("channel gain does not follow written code");
    a_mute_on_zero: assert property (reg_write && reg_addr == 8'h3e && reg_wdata == 8'h00
        |-> ##2 channel_muted)
        else $error("volume code zero did not mute");
    a_vol_floor: assert property (reg_write && reg_addr == 8'h3e && reg_wdata == 8'h01
        |-> ##2 (volume_half_db == 9'h138 && !channel_muted))
        else $error("volume code one level wrong");
    a_vol_unity: assert property (reg_write && reg_addr == 8'h3e && reg_wdata == 8'hc9
        |-> ##2 volume_half_db == 9'h000)
        else $error("unity volume code not zero level");
    a_trim_unity: assert property (reg_write && reg_addr == 8'h3f && reg_wdata[7:4] == 4'h8
        |-> ##2 trim_tenth_db == 5'h00)
        else $error("trim code eight not zero level");
    a_trim_low_zero: assert property ($past(reg_read) && $past(reg_addr) == 8'h3f
        |-> reg_rdata[3:0] == 4'h0)
        else $error("trim register low bits not zero");
endmodule
bind adc_channel_one_config_regs ch1_cfg_regs_asserts u_chk (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .first_channel_input_kind,
    .first_channel_mic_input, .path_analog_diff, .path_analog_single, .path_pdm_mic,
    .path_dc_coupled, .impedance_select_onehot, .dynamic_range_enhancer_on,
    .automatic_gain_controller_on, .channel_gain_db, .channel_muted, .volume_half_db,
    .trim_tenth_db);

// [verification/adc_channel_one_config_regs_tb.sv]
// self-checking bench for the channel one configuration register bank
`timescale 1ns/1ns
module adc_channel_one_config_regs_tb;
    logic        clk_sys, rst_n, reg_write, reg_read;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        kind, mic, p_diff, p_se, p_pdm, dc, enh_on, ctl_on, muted, rsv;
    logic [2:0]  imp;
    logic [5:0]  gain;
    logic [8:0]  vol;
    logic [4:0]  trim;
    int          err_total, tests_run, cycles;
    // address, write data, expected readback
    logic [23:0] rows [11] = '{24'h3c_fffd, 24'h3c_0000, 24'h3d_fffc, 24'h3d_a8a8,
        24'h3e_0000, 24'h3e_ffff, 24'h3f_fff0, 24'h3f_0f00, 24'h6c_ff08, 24'h6c_0000,
        24'h50_ff00};
    logic [7:0]  vcodes [4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
    logic [5:0]  gcodes [4] = '{6'h00, 6'h2a, 6'h2b, 6'h3f};
    logic [3:0]  tcodes [3] = '{4'h0, 4'h8, 4'hf};

    adc_channel_one_config_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .first_channel_input_kind(kind), .first_channel_mic_input(mic),
        .path_analog_diff(p_diff), .path_analog_single(p_se), .path_pdm_mic(p_pdm),
        .path_dc_coupled(dc), .impedance_select_onehot(imp), .dynamic_range_enhancer_on(enh_on),
        .automatic_gain_controller_on(ctl_on), .channel_gain_db(gain), .channel_muted(muted),
        .volume_half_db(vol), .trim_tenth_db(trim), .reserved_code_seen(rsv));

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 3000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
    endtask

    // one-cycle write; strobe drops at the edge, then only a 1 ns wait, so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask

    // one-cycle read, data checked in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        err_total = 0; tests_run = 0; cycles = 0;
        do_reset();
        rd(8'h3c, 8'h00);
        rd(8'h3d, 8'h00);
        rd(8'h3e, 8'hc9);
        rd(8'h3f, 8'h80);
        check(vol, 9'h000);
        check(trim, 5'h00);
        $display("reset values done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        for (int s = 0; s < 4; s++) begin
            // shared pins have no model here; host side keeps them set for each source
            wr(8'h3c, {s[0], s[1:0], 1'b1, 2'h1, 1'b0, 1'b1});
            settle();
            check({kind, mic}, {s[0], !s[0]});
            check({p_pdm, p_se, p_diff}, {s == 2, s == 1, s == 0});
            check(dc, s < 2);
            check(imp, (s < 2) ? 3'h2 : 3'h0);
            check(rsv, s == 3);
            check({ctl_on, enh_on}, 2'h1);
        end
        wr(8'h6c, 8'h08);
        settle();
        check({ctl_on, enh_on}, 2'h2);
        for (int c = 0; c < 4; c++) begin
            wr(8'h3c, {4'h0, c[1:0], 2'h0});
            settle();
            check(imp, (c < 3) ? (3'h1 << c) : 3'h0);
            check({ctl_on, enh_on}, 2'h0);
        end
        $display("input setup done");
        foreach (vcodes[i]) begin
            wr(8'h3e, vcodes[i]);
            settle();
            check(muted, vcodes[i] == 8'h00);
            if (vcodes[i] != 8'h00) check(vol, {1'b0, vcodes[i]} - 9'h0c9);
        end
        foreach (gcodes[i]) begin
            wr(8'h3d, {gcodes[i], 2'h0});
            settle();
            check(gain, (gcodes[i] > 6'h2a) ? 6'h2a : gcodes[i]);
        end
        foreach (tcodes[i]) begin
            wr(8'h3f, {tcodes[i], 4'hf});
            settle();
            check(trim, 5'({1'b0, tcodes[i]} - 5'h08));
        end
        $display("level decode done");
        wr(8'h3e, 8'h00);
        do_reset();
        rd(8'h3e, 8'hc9);
        $display("mid-run reset done");
        print_verdict();
    end
endmodule
